// File: src/mcc_pkg.sv
// Purpose: Shared constants and types for the per-axis chopper and current configuration block
// Assumes: 20 MHz core clock, six axes, plain register port
// Notes on behaviour
// - At standstill, current ramps down over a 4-bit time; zero drops at once.
// - A 10-bit reference pulse width is kept for load-step load measurement.
// - An 8-bit stall sensitivity is kept for load-step mode; larger is more sensitive.
// - Relative move starts from last target (0), actual (1) or encoder (2) position.
// - Microstep code 0..8 decodes to 2^code microsteps per full step.
// - A 2-bit comparator blank time selection is provided to the chopper.
// - Mode bit selects hysteresis chopper (0) or constant off-time chopper (1).
// - In constant off-time mode, disable bit stops comparator ending fast decay.
// - One 4-bit field is hysteresis end or fast decay time, by mode.
// - Field 0..8 is hysteresis start offset on end, or sine offset, by mode.
// - Off time is 12 + 32 * setting clocks, never below 64 clocks.
// - Off-time setting zero switches all bridge transistors off for free-wheeling.
// - Minimum regulated current is half of run current (0) or quarter (1).
// - Current decrements once per 32, 8, 2 or 1 readings above upper threshold.
// - Upper threshold is lower threshold plus hysteresis field plus one, in steps of 32.
// - Each reading below lower threshold raises current by 1, 2, 4 or 8.
// - Lower threshold comes from the 4-bit lower threshold setting, times 32.
package mcc_pkg;
    localparam int MCC_NAXES = 6;
    localparam int MCC_AW = 11;
    localparam int MCC_DW = 16;
    // Parameter numbers; address is {axis, number}
    localparam logic [7:0] MCC_PAR_RAMP = 8'h1f;
    localparam logic [7:0] MCC_PAR_PULSE = 8'h20;
    localparam logic [7:0] MCC_PAR_SENS = 8'h21;
    localparam logic [7:0] MCC_PAR_ORIGIN = 8'h7f;
    localparam logic [7:0] MCC_PAR_USTEP = 8'h8c;
    localparam logic [7:0] MCC_PAR_BLANK = 8'ha2;
    localparam logic [7:0] MCC_PAR_MODE = 8'ha3;
    localparam logic [7:0] MCC_PAR_FDOFF = 8'ha4;
    localparam logic [7:0] MCC_PAR_HEND = 8'ha5;
    localparam logic [7:0] MCC_PAR_HSTART = 8'ha6;
    localparam logic [7:0] MCC_PAR_CHOPPER_OFF_TIME = 8'ha7;
    localparam logic [7:0] MCC_PAR_MIN_CURRENT = 8'ha8;
    localparam logic [7:0] MCC_PAR_DN = 8'ha9;
    localparam logic [7:0] MCC_PAR_HYST = 8'haa;
    localparam logic [7:0] MCC_PAR_UP = 8'hab;
    localparam logic [7:0] MCC_PAR_LOTHR = 8'hac;
    localparam logic [7:0] MCC_PAR_ACTCUR = 8'hb4;
    // Field limits
    localparam logic [3:0] MCC_USTEP_MAX = 4'h8;
    localparam logic [3:0] MCC_HSTART_MAX = 4'h8;
    // Reset values
    localparam logic [3:0] MCC_RST_USTEP = 4'h8;
    localparam logic [1:0] MCC_RST_BLANK = 2'h2;
    localparam logic [4:0] MCC_RST_RAMP_LVL = 5'h1f;
    // Chopper off time
    localparam int MCC_OFF_TIME_BASE = 12;
    localparam int MCC_OFF_TIME_MULT = 32;
    localparam int MCC_OFF_TIME_MIN = 64;
    // Regulation threshold scale
    localparam int MCC_THR_SHIFT = 5;
    // Power-down ramp: unit 0.16384 s, 32 current levels per unit
    localparam real MCC_CLK_HZ = 20.0e6;
    localparam real MCC_RAMP_UNIT_S = 0.16384;
    localparam int MCC_RAMP_LEVELS = 32;
    localparam int MCC_RAMP_STEP_CYC = int'(MCC_RAMP_UNIT_S * MCC_CLK_HZ) / MCC_RAMP_LEVELS;

    typedef struct packed {
        logic [3:0] ramp;
        logic [9:0] pulse;
        logic [7:0] sens;
        logic [1:0] origin;
        logic [3:0] ustep;
        logic [1:0] blank;
        logic mode;
        logic fd_off;
        logic [3:0] hend;
        logic [3:0] hstart;
        logic [3:0] chopper_off_time;
        logic regulation_min_current;
        logic [1:0] dn;
        logic [3:0] hyst;
        logic [1:0] up;
        logic [3:0] lo_thr;
    } mcc_cfg_t;

    typedef struct packed {
        logic standstill;
        logic [4:0] hold_cur;
        logic [4:0] run_cur;
        logic chop_start;
        logic load_valid;
        logic [9:0] load_val;
        logic rel_cmd;
        logic [31:0] last_target;
        logic [31:0] actual_pos;
        logic [31:0] enc_pos;
    } mcc_axis_in_t;

    typedef struct packed {
        logic [8:0] ustep_per_full;
        logic [1:0] blank_sel;
        logic const_off_mode;
        logic cmp_term_en;
        logic [3:0] hyst_end;
        logic [4:0] hyst_start_tot;
        logic [3:0] fast_decay;
        logic [3:0] sine_off;
        logic off_active;
        logic bridge_off;
        logic [9:0] pulse_time;
        logic [7:0] stall_sens;
        logic [4:0] coil_cur;
        logic [31:0] rel_start;
    } mcc_axis_out_t;
endpackage

// File: src/mcc_axis_cfg.sv
// Purpose: Per-axis chopper, microstep, power-down and load-based current settings
// Assumes: Inputs synchronous to core_clk; clk_en low freezes all state
// Notes: Register read data appear in the cycle after the read strobe
`timescale 1ns/1ns
module mcc_axis_cfg import mcc_pkg::*; #(
    parameter int NAXES = MCC_NAXES,
    parameter int RAMP_STEP_CYC = MCC_RAMP_STEP_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // Register port
    input wire logic [MCC_AW-1:0] reg_addr,
    input wire logic [MCC_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [MCC_DW-1:0] reg_rdata,
    // Axes
    input wire mcc_axis_in_t [NAXES-1:0] axis_in,
    output mcc_axis_out_t [NAXES-1:0] axis_out
);

    function automatic mcc_cfg_t cfg_write(input mcc_cfg_t c, input logic [7:0] p, input logic [MCC_DW-1:0] d);
        mcc_cfg_t n;
        n = c;
        case (p)
            MCC_PAR_RAMP: n.ramp = d[3:0];
            MCC_PAR_PULSE: n.pulse = d[9:0];
            MCC_PAR_SENS: n.sens = d[7:0];
            MCC_PAR_ORIGIN: n.origin = d[1:0];
            MCC_PAR_USTEP: n.ustep = (d[3:0] > MCC_USTEP_MAX) ? MCC_USTEP_MAX : d[3:0];
            MCC_PAR_BLANK: n.blank = d[1:0];
            MCC_PAR_MODE: n.mode = d[0];
            MCC_PAR_FDOFF: n.fd_off = d[0];
            MCC_PAR_HEND: n.hend = d[3:0];
            MCC_PAR_HSTART: n.hstart = (d[3:0] > MCC_HSTART_MAX) ? MCC_HSTART_MAX : d[3:0];
            MCC_PAR_CHOPPER_OFF_TIME: n.chopper_off_time = d[3:0];
            MCC_PAR_MIN_CURRENT: n.regulation_min_current = d[0];
            MCC_PAR_DN: n.dn = d[1:0];
            MCC_PAR_HYST: n.hyst = d[3:0];
            MCC_PAR_UP: n.up = d[1:0];
            MCC_PAR_LOTHR: n.lo_thr = d[3:0];
            default: n = c;
        endcase
        return n;
    endfunction

    function automatic logic [MCC_DW-1:0] cfg_read(input mcc_cfg_t c, input logic [7:0] p, input logic [4:0] cur);
        logic [MCC_DW-1:0] r;
        r = '0;
        case (p)
            MCC_PAR_RAMP: r[3:0] = c.ramp;
            MCC_PAR_PULSE: r[9:0] = c.pulse;
            MCC_PAR_SENS: r[7:0] = c.sens;
            MCC_PAR_ORIGIN: r[1:0] = c.origin;
            MCC_PAR_USTEP: r[3:0] = c.ustep;
            MCC_PAR_BLANK: r[1:0] = c.blank;
            MCC_PAR_MODE: r[0] = c.mode;
            MCC_PAR_FDOFF: r[0] = c.fd_off;
            MCC_PAR_HEND: r[3:0] = c.hend;
            MCC_PAR_HSTART: r[3:0] = c.hstart;
            MCC_PAR_CHOPPER_OFF_TIME: r[3:0] = c.chopper_off_time;
            MCC_PAR_MIN_CURRENT: r[0] = c.regulation_min_current;
            MCC_PAR_DN: r[1:0] = c.dn;
            MCC_PAR_HYST: r[3:0] = c.hyst;
            MCC_PAR_UP: r[1:0] = c.up;
            MCC_PAR_LOTHR: r[3:0] = c.lo_thr;
            MCC_PAR_ACTCUR: r[4:0] = cur;
            default: r = '0;
        endcase
        return r;
    endfunction

    mcc_cfg_t cfg_q [NAXES];
    logic [4:0] cur_q [NAXES];
    logic [MCC_DW-1:0] rdata_q;

    // Address split
    wire [2:0] a_axis = reg_addr[MCC_AW-1:8];
    wire [7:0] a_par = reg_addr[7:0];
    wire a_ok = (32'(a_axis) < NAXES);
    wire [MCC_DW-1:0] rd_word = a_ok ? cfg_read(cfg_q[a_axis], a_par, cur_q[a_axis]) : '0;

    assign reg_rdata = rdata_q;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= '0;
        end else if (clk_en) begin
            rdata_q <= reg_rd ? rd_word : '0;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NAXES; g++) begin : g_axis
            mcc_axis_in_t ai;
            mcc_cfg_t c;
            logic [8:0] off_q;
            logic [4:0] dcnt_q;
            logic [4:0] lvl_q;
            logic [31:0] rt_q;
            mcc_axis_out_t out_q;
            assign ai = axis_in[g];
            assign c = cfg_q[g];
            assign axis_out[g] = out_q;

            // Setting storage for this axis
            wire wr_me = reg_wr && a_ok && (32'(a_axis) == g);
            always_ff @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    cfg_q[g] <= '{ustep: MCC_RST_USTEP, blank: MCC_RST_BLANK, default: '0};
                end else if (clk_en && wr_me) begin
                    cfg_q[g] <= cfg_write(c, a_par, reg_wdata);
                end
            end

            // Off time: 12 + 32*setting, floor at 64
            wire [8:0] off_raw = 9'(MCC_OFF_TIME_BASE) + 9'(MCC_OFF_TIME_MULT) * 9'(c.chopper_off_time);
            wire [8:0] off_len = (off_raw < 9'(MCC_OFF_TIME_MIN)) ? 9'(MCC_OFF_TIME_MIN) : off_raw;
            wire bridge_off = (c.chopper_off_time == 4'h0);
            // Load full length so off_active stands exactly off_len cycles
            wire [8:0] off_d = (ai.chop_start && !bridge_off) ? off_len :
                               (off_q != 9'h000) ? off_q - 9'h001 : 9'h000;

            // Load-based regulation thresholds
            wire [10:0] lo_thr = 11'(c.lo_thr) << MCC_THR_SHIFT;
            wire [10:0] hi_thr = 11'(6'(c.lo_thr) + 6'(c.hyst) + 6'h01) << MCC_THR_SHIFT;
            wire [10:0] load = 11'(ai.load_val);
            wire [4:0] min_cur = c.regulation_min_current ? (ai.run_cur >> 2) : (ai.run_cur >> 1);
            wire [3:0] up_step = 4'h1 << c.up;
            logic [5:0] dn_n;
            always_comb begin
                case (c.dn)
                    2'h0: dn_n = 6'h20;
                    2'h1: dn_n = 6'h08;
                    2'h2: dn_n = 6'h02;
                    default: dn_n = 6'h01;
                endcase
            end
            wire below = ai.load_valid && (load < lo_thr);
            wire above = ai.load_valid && (load > hi_thr);
            wire dn_due = (6'(dcnt_q) + 6'h01) >= dn_n;
            wire [5:0] cur_up = 6'(cur_q[g]) + 6'(up_step);
            wire [4:0] cur_lim = (cur_q[g] > ai.run_cur) ? ai.run_cur : cur_q[g];
            wire [4:0] cur_inc = (cur_up > 6'(ai.run_cur)) ? ai.run_cur : cur_up[4:0];
            wire [4:0] cur_dec = (cur_lim > min_cur) ? cur_lim - 5'h01 : min_cur;
            wire [4:0] cur_d = below ? cur_inc : (above && dn_due) ? cur_dec : cur_lim;
            wire [4:0] dcnt_d = below ? 5'h00 : above ? (dn_due ? 5'h00 : dcnt_q + 5'h01) : dcnt_q;

            // Power-down ramp toward hold current
            wire [31:0] rt_lim = 32'(c.ramp) * 32'(RAMP_STEP_CYC);
            wire lvl_hi = lvl_q > ai.hold_cur;
            wire rt_done = (rt_q + 32'h1) >= rt_lim;
            wire [4:0] lvl_d = !ai.standstill ? MCC_RST_RAMP_LVL :
                               !lvl_hi ? ai.hold_cur :
                               (c.ramp == 4'h0) ? ai.hold_cur :
                               rt_done ? lvl_q - 5'h01 : lvl_q;
            wire [31:0] rt_d = (!ai.standstill || !lvl_hi || rt_done) ? 32'h0 : rt_q + 32'h1;

            // Relative move start point
            logic [31:0] rel_sel;
            always_comb begin
                case (c.origin)
                    2'h1: rel_sel = ai.actual_pos;
                    2'h2: rel_sel = ai.enc_pos;
                    default: rel_sel = ai.last_target;
                endcase
            end

            // Chopper decode
            mcc_axis_out_t o_d;
            always_comb begin
                o_d = out_q;
                o_d.ustep_per_full = 9'h001 << c.ustep;
                o_d.blank_sel = c.blank;
                o_d.const_off_mode = c.mode;
                o_d.cmp_term_en = !(c.mode && c.fd_off);
                o_d.hyst_end = c.mode ? 4'h0 : c.hend;
                o_d.fast_decay = c.mode ? c.hend : 4'h0;
                o_d.hyst_start_tot = c.mode ? 5'h00 : 5'(c.hend) + 5'(c.hstart);
                o_d.sine_off = c.mode ? c.hstart : 4'h0;
                o_d.off_active = (off_d != 9'h000);
                o_d.bridge_off = bridge_off;
                o_d.pulse_time = c.pulse;
                o_d.stall_sens = c.sens;
                o_d.coil_cur = (cur_d < lvl_d) ? cur_d : lvl_d;
                if (ai.rel_cmd) begin
                    o_d.rel_start = rel_sel;
                end
            end

            always_ff @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    off_q <= '0;
                    dcnt_q <= '0;
                    cur_q[g] <= '0;
                    lvl_q <= MCC_RST_RAMP_LVL;
                    rt_q <= '0;
                    out_q <= '0;
                end else if (clk_en) begin
                    off_q <= off_d;
                    dcnt_q <= dcnt_d;
                    cur_q[g] <= cur_d;
                    lvl_q <= lvl_d;
                    rt_q <= rt_d;
                    out_q <= o_d;
                end
            end
        end
    endgenerate

endmodule

// File: test/mcc_axis_cfg_monitor.sv
// Purpose: Port assertions for the axis configuration block, axis 0
// Assumes: Bound into mcc_axis_cfg
// Notes: live_q skips the first edge after reset
`timescale 1ns/1ns
module mcc_axis_cfg_monitor import mcc_pkg::*; #(
    parameter int NAXES = MCC_NAXES,
    parameter int RAMP_STEP_CYC = MCC_RAMP_STEP_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // Register port
    input wire logic [MCC_AW-1:0] reg_addr,
    input wire logic [MCC_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [MCC_DW-1:0] reg_rdata,
    // Axes
    input wire mcc_axis_in_t [NAXES-1:0] axis_in,
    input wire mcc_axis_out_t [NAXES-1:0] axis_out
);
    logic live_q;
    logic [8:0] off_len_q;
    mcc_axis_out_t o;
    assign o = axis_out[0];
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            live_q <= 1'b0;
            off_len_q <= 9'h0;
        end else begin
            live_q <= 1'b1;
            off_len_q <= o.off_active ? off_len_q + 9'h1 : 9'h0;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence rel_taken;
        live_q && $past(axis_in[0].rel_cmd);
    endsequence
    rdata_idle_a: assert property (live_q && $past(clk_en) && !$past(reg_rd) |-> reg_rdata == '0)
        else $error("read data not idle");
    unmapped_axis_a: assert property (live_q && $past(clk_en) && $past(reg_rd) && $past(reg_addr) >= 11'h600
        |-> reg_rdata == '0)
        else $error("unmapped read not zero");
    ustep_onehot_a: assert property (live_q |-> $onehot(o.ustep_per_full)) else $error("step decode not one-hot");
    hyst_mode_a: assert property (live_q && !o.const_off_mode |-> o.fast_decay == 0 && o.sine_off == 0 && o.cmp_term_en)
        else $error("hysteresis mode fields wrong");
    const_mode_a: assert property (live_q && o.const_off_mode |-> o.hyst_end == 0 && o.hyst_start_tot == 0)
        else $error("constant off mode fields wrong");
    hyst_offset_a: assert property (live_q && !o.const_off_mode |-> o.hyst_start_tot >= o.hyst_end)
        else $error("start not offset on end");
    off_min_a: assert property (live_q && $fell(o.off_active) |-> off_len_q >= 9'(MCC_OFF_TIME_MIN))
        else $error("off time too short");
    free_wheel_a: assert property (live_q && o.bridge_off && $past(axis_in[0].chop_start) |-> !$rose(o.off_active))
        else $error("off time started with bridge off");
    cur_clamp_a: assert property (live_q && $stable(axis_in[0].run_cur) |-> o.coil_cur <= axis_in[0].run_cur)
        else $error("current above run current");
    rel_origin_a: assert property (rel_taken |-> o.rel_start == $past(axis_in[0].last_target) ||
        o.rel_start == $past(axis_in[0].actual_pos) || o.rel_start == $past(axis_in[0].enc_pos)) else $error("bad start");
endmodule
bind mcc_axis_cfg mcc_axis_cfg_monitor #(.NAXES(NAXES), .RAMP_STEP_CYC(RAMP_STEP_CYC)) u_mon (.core_clk(core_clk),
    .rst_b(rst_b), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .axis_in(axis_in), .axis_out(axis_out));

// File: test/mcc_motor_model.sv
// Purpose: Motor side of every axis: load readings, positions, currents
// Assumes: Bench gives pulses and levels
// Notes: Load value inverts while not valid
`timescale 1ns/1ns
module mcc_motor_model import mcc_pkg::*; #(
    parameter int NAXES = MCC_NAXES
) (
    // Bench control
    input wire logic still,
    input wire logic [9:0] load_lvl,
    input wire logic load_go,
    input wire logic chop_go,
    input wire logic rel_go,
    // To block
    output mcc_axis_in_t [NAXES-1:0] axis_in
);
    always_comb begin
        for (int i = 0; i < NAXES; i++) begin
            axis_in[i] = '0;
            axis_in[i].standstill = still;
            axis_in[i].hold_cur = 5'h2;
            axis_in[i].run_cur = 5'h10;
            axis_in[i].chop_start = chop_go;
            axis_in[i].load_valid = load_go;
            axis_in[i].load_val = load_go ? load_lvl : ~load_lvl;
            axis_in[i].rel_cmd = rel_go;
            axis_in[i].last_target = 32'h11;
            axis_in[i].actual_pos = 32'h22;
            axis_in[i].enc_pos = 32'h33;
        end
    end
endmodule

// File: test/test_stepper_chopper_current_config.sv
// Purpose: Self-checking bench for the axis configuration block
// Assumes: Ramp step shortened to 4 cycles
// Notes: Reset reads first, then table rows, then hand-written cases
`timescale 1ns/1ns
module test_stepper_chopper_current_config import mcc_pkg::*;;
    typedef struct packed {logic [10:0] a; logic [15:0] d; logic [15:0] e;} mcc_row_t;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic clk_en = 1'b1;
    logic [MCC_AW-1:0] reg_addr = '0;
    logic [MCC_DW-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [MCC_DW-1:0] reg_rdata;
    logic still = 1'b0;
    logic load_go = 1'b0;
    logic chop_go = 1'b0;
    logic rel_go = 1'b0;
    logic [9:0] load_lvl = '0;
    mcc_axis_in_t [MCC_NAXES-1:0] axis_in;
    mcc_axis_out_t [MCC_NAXES-1:0] axis_out;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int n;
    logic [31:0] pos [4] = '{32'h11, 32'h22, 32'h33, 32'h11};
    int offn [3] = '{0, 64, 76};
    mcc_row_t rows [18] = '{'{11'h01f, 16'hf, 16'hf}, '{11'h120, 16'h3ff, 16'h3ff}, '{11'h221, 16'hff, 16'hff},
        '{11'h37f, 16'h2, 16'h2}, '{11'h48c, 16'hf, 16'h8}, '{11'h5a2, 16'h3, 16'h3}, '{11'h0a3, 16'h1, 16'h1},
        '{11'h0a4, 16'h1, 16'h1}, '{11'h0a5, 16'hf, 16'hf}, '{11'h0a6, 16'h9, 16'h8}, '{11'h0a7, 16'hf, 16'hf},
        '{11'h0a8, 16'h1, 16'h1}, '{11'h0a9, 16'h3, 16'h3}, '{11'h0aa, 16'hf, 16'hf}, '{11'h0ab, 16'h3, 16'h3},
        '{11'h0ac, 16'hf, 16'hf}, '{11'h61f, 16'h5, 16'h0}, '{11'h030, 16'h5, 16'h0}};
    mcc_axis_cfg #(.NAXES(MCC_NAXES), .RAMP_STEP_CYC(4)) u_dut (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .axis_in(axis_in), .axis_out(axis_out));
    mcc_motor_model #(.NAXES(MCC_NAXES)) u_motor (.still(still), .load_lvl(load_lvl), .load_go(load_go),
        .chop_go(chop_go), .rel_go(rel_go), .axis_in(axis_in));
    initial begin
        forever #25 core_clk = ~core_clk;
    end
    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic step();
        @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [10:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_chk(input string name, input logic [10:0] a, input logic [15:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(name, {16'h0, e}, {16'h0, reg_rdata});
    endtask
    task automatic hold(input int k, input logic [9:0] l, input logic [4:0] e);
        @(posedge core_clk);
        load_lvl <= l;
        load_go <= 1'b1;
        repeat (k) @(posedge core_clk);
        load_go <= 1'b0;
        step();
        step();
        chk("coil current", 32'(e), 32'(axis_out[0].coil_cur));
    endtask
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            summarize();
        end
    end
    initial begin
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        rd_chk("ustep reset", 11'h08c, 16'h8);
        rd_chk("blank reset", 11'h0a2, 16'h2);
        chk("bridge off", 32'h1, 32'(axis_out[0].bridge_off));
        for (int i = 0; i < 18; i++) begin
            wr(rows[i].a, rows[i].d);
            rd_chk("table read", rows[i].a, rows[i].e);
        end
        rd_chk("other axis ramp", 11'h11f, 16'h0);
        chk("blank sel", 32'h3, 32'(axis_out[5].blank_sel));
        chk("pulse time", 32'h3ff, 32'(axis_out[1].pulse_time));
        chk("stall sens", 32'hff, 32'(axis_out[2].stall_sens));
        for (int c = 0; c < 9; c++) begin
            wr(11'h08c, 16'(c));
            step();
            chk("ustep per full", 32'h1 << c, 32'(axis_out[0].ustep_per_full));
        end
        wr(11'h0a3, 16'h0);
        wr(11'h0a5, 16'h3);
        wr(11'h0a6, 16'h2);
        step();
        chk("hyst end", 32'h3, 32'(axis_out[0].hyst_end));
        chk("hyst start", 32'h5, 32'(axis_out[0].hyst_start_tot));
        wr(11'h0a3, 16'h1);
        step();
        chk("fast decay", 32'h3, 32'(axis_out[0].fast_decay));
        chk("sine offset", 32'h2, 32'(axis_out[0].sine_off));
        chk("cmp term", 32'h0, 32'(axis_out[0].cmp_term_en));
        wr(11'h0a4, 16'h0);
        step();
        chk("cmp term", 32'h1, 32'(axis_out[0].cmp_term_en));
        chk("const off", 32'h1, 32'(axis_out[0].const_off_mode));
        for (int t = 0; t < 3; t++) begin
            wr(11'h0a7, 16'(t));
            @(posedge core_clk);
            chop_go <= 1'b1;
            @(posedge core_clk);
            chop_go <= 1'b0;
            n = 0;
            repeat (90) begin
                #1;
                n += int'(axis_out[0].off_active);
                @(posedge core_clk);
            end
            chk("off cycles", 32'(offn[t]), 32'(n));
        end
        for (int o = 0; o < 4; o++) begin
            wr(11'h07f, 16'(o));
            @(posedge core_clk);
            rel_go <= 1'b1;
            @(posedge core_clk);
            rel_go <= 1'b0;
            #1;
            chk("rel start", pos[o], axis_out[0].rel_start);
        end
        wr(11'h0ac, 16'h1);
        wr(11'h0aa, 16'h0);
        wr(11'h0a9, 16'h3);
        wr(11'h0a8, 16'h0);
        hold(4, 10'd0, 5'd16);
        hold(40, 10'd100, 5'd8);
        wr(11'h0a8, 16'h1);
        hold(40, 10'd100, 5'd4);
        hold(1, 10'd10, 5'd12);
        hold(8, 10'd50, 5'd12);
        wr(11'h0a9, 16'h0);
        hold(32, 10'd100, 5'd11);
        rd_chk("actual current", 11'h0b4, 16'h000b);
        wr(11'h01f, 16'h1);
        @(posedge core_clk);
        still <= 1'b1;
        repeat (8) step();
        chk("ramp slow", 32'd11, 32'(axis_out[0].coil_cur));
        repeat (130) step();
        chk("ramp end", 32'd2, 32'(axis_out[0].coil_cur));
        // Clock enable low: write must not land
        @(posedge core_clk);
        clk_en <= 1'b0;
        wr(11'h01f, 16'h7);
        clk_en <= 1'b1;
        rd_chk("frozen write", 11'h01f, 16'h1);
        // Reset in mid-run restores settings
        @(posedge core_clk);
        rst_b <= 1'b0;
        @(posedge core_clk);
        rst_b <= 1'b1;
        rd_chk("ustep rerun", 11'h08c, 16'h8);
        rd_chk("ramp rerun", 11'h01f, 16'h0);
        chk("bridge rerun", 32'h1, 32'(axis_out[0].bridge_off));
        summarize();
    end
endmodule
